/* File: common/gw_pkg.sv */
`default_nettype none
package gw_pkg;
  // Clock rate and status refresh period
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned REFRESH_TIME_MS = 1000;
  localparam int unsigned REFRESH_CYCLES =
    REFRESH_TIME_MS * (CLK_FREQ_HZ / 1000);

  // Word register numbers as seen by the host
  localparam logic [15:0] ADDR_IN_STATUS_LO = 16'h0001;
  localparam logic [15:0] ADDR_IN_STATUS_HI = 16'h0002;
  localparam logic [15:0] ADDR_LINK_STATE = 16'h0101;
  localparam logic [15:0] ADDR_FAULT_FLAGS = 16'h0102;
  localparam logic [15:0] ADDR_ERR_COUNT = 16'h0103;
  localparam logic [15:0] ADDR_BUSOFF_COUNT = 16'h0104;
  localparam logic [15:0] ADDR_OVERRUN_COUNT = 16'h0105;
  localparam logic [15:0] ADDR_SPARE = 16'h0106;
  localparam logic [15:0] ADDR_RUN_LO = 16'h0401;
  localparam logic [15:0] ADDR_RUN_HI = 16'h0402;
  localparam logic [15:0] ADDR_CMD_LO = 16'h0403;
  localparam logic [15:0] ADDR_CMD_HI = 16'h0404;

  // Command word fields (low word)
  localparam int unsigned CMD_LOCAL_RUN_BIT = 0;
  localparam int unsigned CMD_FAULT_CLR_BIT = 1;
  localparam int unsigned CMD_MOD_RST_BIT = 4;
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0013;
  // Run/idle word field
  localparam int unsigned SYS_RUN_BIT = 0;
  localparam logic [15:0] SYS_RUN_MASK = 16'h0001;

  // Input status word fields
  localparam int unsigned IST_RUN_BIT = 0;
  localparam int unsigned IST_ONLINE_BIT = 1;
  localparam int unsigned IST_FAULT_BIT = 2;

  // Fault word fields
  localparam int unsigned FLT_ADDR_CLAIM = 0;
  localparam int unsigned FLT_WARNING = 1;
  localparam int unsigned FLT_BUS_OFF = 2;
  localparam int unsigned FLT_OVERRUN = 3;
  localparam int unsigned FLT_FRAGMENT = 4;
  localparam int unsigned FLT_RX_QUEUE = 5;
  localparam int unsigned FLT_TX_QUEUE = 6;
  localparam int unsigned FLT_COUNT = 7;

  // Link state codes
  localparam logic [15:0] LINK_OFFLINE = 16'h8000;
  localparam logic [15:0] LINK_ONLINE = 16'h8001;
  localparam logic [15:0] LINK_INIT = 16'h8002;

  // Reset and increment values
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
endpackage
`default_nettype wire

/* File: core/word_swap.sv */
`default_nettype none
// Optional exchange of the two bytes of every 16-bit word
module word_swap #(
  parameter int unsigned WORDS = 1
) (
  input wire logic swap_en,
  input wire logic [16*WORDS-1:0] din,
  output logic [16*WORDS-1:0] dout
);
  // One lane per word; content is never interpreted
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_lane
      assign dout[16*gi +: 16] = swap_en ?
        {din[16*gi +: 8], din[16*gi+8 +: 8]} : din[16*gi +: 16];
    end
  endgenerate
endmodule // word_swap
`default_nettype wire

/* File: core/gateway_status_command_bank.sv */
`default_nettype none
module gateway_status_command_bank #(
  parameter int unsigned REFRESH_CYCLES = gw_pkg::REFRESH_CYCLES,
  parameter int unsigned DATA_WORDS = 1
) (
  input wire logic clk,
  input wire logic nrst,
  // Host word register port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  output logic resp_err,
  // Vehicle network state and events
  input wire logic link_online,
  input wire logic link_initializing,
  input wire logic addr_claim_failed,
  input wire logic err_warning,
  input wire logic bus_off,
  input wire logic can_error_evt,
  input wire logic rx_overrun_evt,
  input wire logic fragment_transfer_error,
  input wire logic rx_queue_overflow,
  input wire logic tx_queue_overflow,
  // I/O data path
  input wire logic swap_en,
  input wire logic [16*DATA_WORDS-1:0] host_out_data,
  input wire logic [16*DATA_WORDS-1:0] veh_in_data,
  output logic [16*DATA_WORDS-1:0] veh_out_data,
  output logic [16*DATA_WORDS-1:0] host_in_data,
  // Mode and reset outputs
  output logic run_mode,
  output logic module_reset
);
  localparam int unsigned DW = 16 * DATA_WORDS;
  localparam logic [31:0] TICK_LAST = 32'(REFRESH_CYCLES - 1);

  // Host-written state
  logic sys_run_q, sys_run_d; // System run bit
  logic local_run_q, local_run_d; // Local run bit
  logic fclr_bit_q, fclr_bit_d; // Readback of fault-clear bit
  logic mrst_q, mrst_d; // Module reset pulse
  // Live fault and counter state
  logic [gw_pkg::FLT_COUNT-1:1] sticky_q, sticky_d;
  logic [15:0] err_cnt_q, err_cnt_d;
  logic [15:0] boff_cnt_q, boff_cnt_d;
  logic [15:0] ovr_cnt_q, ovr_cnt_d;
  logic bus_off_prev_q, bus_off_prev_d; // Edge detect of bus-off level
  // Snapshot seen by the host
  logic [15:0] snap_state_q, snap_state_d;
  logic [15:0] snap_fault_q, snap_fault_d;
  logic [15:0] snap_err_q, snap_err_d;
  logic [15:0] snap_boff_q, snap_boff_d;
  logic [15:0] snap_ovr_q, snap_ovr_d;
  logic [31:0] tick_q, tick_d; // Refresh interval counter
  // Outputs
  logic run_q, run_d;
  logic [2:0] ist_q, ist_d; // Input status bits 2..0
  logic resp_valid_q, resp_valid_d;
  logic [15:0] resp_rdata_q, resp_rdata_d;
  logic resp_err_q, resp_err_d;
  logic [DW-1:0] veh_out_q, host_in_q;
  logic [DW-1:0] veh_out_sw, host_in_sw;

  // Decoded strobes
  logic wr_run, wr_cmd, fault_clear, bus_off_evt, tick;
  logic [15:0] live_state, live_fault;

  // Both directions share one swapper style; content untouched
  word_swap #(.WORDS(DATA_WORDS)) u_swap_out (
    .swap_en(swap_en),
    .din(host_out_data),
    .dout(veh_out_sw)
  );
  word_swap #(.WORDS(DATA_WORDS)) u_swap_in (
    .swap_en(swap_en),
    .din(veh_in_data),
    .dout(host_in_sw)
  );

  // Write decode and event shaping
  always_comb begin
    wr_run = req_valid && req_write && (req_addr == gw_pkg::ADDR_RUN_LO);
    wr_cmd = req_valid && req_write && (req_addr == gw_pkg::ADDR_CMD_LO);
    // Clear takes effect in the same cycle the write is taken
    fault_clear = wr_cmd && req_wdata[gw_pkg::CMD_FAULT_CLR_BIT];
    bus_off_evt = bus_off && !bus_off_prev_q;
    tick = (tick_q == TICK_LAST);
    // Initializing wins over online: claim still in progress
    if (link_initializing) begin
      live_state = gw_pkg::LINK_INIT;
    end else if (link_online) begin
      live_state = gw_pkg::LINK_ONLINE;
    end else begin
      live_state = gw_pkg::LINK_OFFLINE;
    end
    // Bits 7..15 stay zero
    live_fault = {9'h000, sticky_q, addr_claim_failed};
  end

  // Next values of host-written and fault state
  always_comb begin
    sys_run_d = sys_run_q;
    local_run_d = local_run_q;
    fclr_bit_d = fclr_bit_q;
    mrst_d = 1'b0;
    // Host owns the system run bit
    if (wr_run) begin
      sys_run_d = req_wdata[gw_pkg::SYS_RUN_BIT];
    end
    // Only bits 0, 1 and 4 are kept; others are dropped
    if (wr_cmd) begin
      local_run_d = req_wdata[gw_pkg::CMD_LOCAL_RUN_BIT];
      fclr_bit_d = req_wdata[gw_pkg::CMD_FAULT_CLR_BIT];
      mrst_d = req_wdata[gw_pkg::CMD_MOD_RST_BIT];
    end
    bus_off_prev_d = bus_off;
    // A new fault in the clearing cycle survives the clear
    sticky_d = fault_clear ? '0 : sticky_q;
    sticky_d = sticky_d | {tx_queue_overflow, rx_queue_overflow,
      fragment_transfer_error, rx_overrun_evt, bus_off,
      err_warning};
    // Counters wrap at 16 bits; an event in the clear cycle counts one
    err_cnt_d = fault_clear ? gw_pkg::WORD_ZERO : err_cnt_q;
    boff_cnt_d = fault_clear ? gw_pkg::WORD_ZERO : boff_cnt_q;
    ovr_cnt_d = fault_clear ? gw_pkg::WORD_ZERO : ovr_cnt_q;
    if (can_error_evt) begin
      err_cnt_d = err_cnt_d + gw_pkg::COUNT_ONE;
    end
    if (bus_off_evt) begin
      boff_cnt_d = boff_cnt_d + gw_pkg::COUNT_ONE;
    end
    if (rx_overrun_evt) begin
      ovr_cnt_d = ovr_cnt_d + gw_pkg::COUNT_ONE;
    end
  end

  // Next values of the host-visible snapshot
  always_comb begin
    tick_d = tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
    snap_state_d = snap_state_q;
    snap_fault_d = snap_fault_q;
    snap_err_d = snap_err_q;
    snap_boff_d = snap_boff_q;
    snap_ovr_d = snap_ovr_q;
    // Refresh on the interval; a clear is shown at once and beats a tick
    if (tick || fault_clear) begin
      snap_state_d = live_state;
      snap_fault_d = {live_fault[15:1] & {15{!fault_clear}},
        live_fault[gw_pkg::FLT_ADDR_CLAIM]};
      snap_err_d = fault_clear ? gw_pkg::WORD_ZERO : err_cnt_q;
      snap_boff_d = fault_clear ? gw_pkg::WORD_ZERO : boff_cnt_q;
      snap_ovr_d = fault_clear ? gw_pkg::WORD_ZERO : ovr_cnt_q;
    end
  end

  // Next values of mode, status and the read answer
  always_comb begin
    run_d = sys_run_q && local_run_q;
    ist_d = {(live_fault != gw_pkg::WORD_ZERO), link_online,
      run_q};
    resp_valid_d = req_valid;
    resp_err_d = 1'b0;
    resp_rdata_d = gw_pkg::WORD_ZERO;
    if (req_valid) begin
      case (req_addr)
        gw_pkg::ADDR_IN_STATUS_LO: resp_rdata_d = {13'h0000, ist_q};
        gw_pkg::ADDR_LINK_STATE: resp_rdata_d = snap_state_q;
        gw_pkg::ADDR_FAULT_FLAGS: resp_rdata_d = snap_fault_q;
        gw_pkg::ADDR_ERR_COUNT: resp_rdata_d = snap_err_q;
        gw_pkg::ADDR_BUSOFF_COUNT: resp_rdata_d = snap_boff_q;
        gw_pkg::ADDR_OVERRUN_COUNT: resp_rdata_d = snap_ovr_q;
        gw_pkg::ADDR_RUN_LO: resp_rdata_d = {15'h0000, sys_run_q};
        gw_pkg::ADDR_CMD_LO: begin
          resp_rdata_d = {11'h000, mrst_q, 2'b00, fclr_bit_q,
            local_run_q};
        end
        // Upper halves and the spare word read zero
        gw_pkg::ADDR_IN_STATUS_HI, gw_pkg::ADDR_SPARE,
        gw_pkg::ADDR_RUN_HI, gw_pkg::ADDR_CMD_HI: begin
          resp_rdata_d = gw_pkg::WORD_ZERO;
        end
        default: resp_err_d = 1'b1;
      endcase
      // Input-area words cannot be written
      if (req_write && (req_addr < gw_pkg::ADDR_RUN_LO)) begin
        resp_err_d = 1'b1;
        resp_rdata_d = gw_pkg::WORD_ZERO;
      end
    end
  end

  // Registers; a module reset pulse restores every control state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_run_q <= 1'b0;
      local_run_q <= 1'b0;
      fclr_bit_q <= 1'b0;
      mrst_q <= 1'b0;
      sticky_q <= '0;
      err_cnt_q <= gw_pkg::WORD_ZERO;
      boff_cnt_q <= gw_pkg::WORD_ZERO;
      ovr_cnt_q <= gw_pkg::WORD_ZERO;
      bus_off_prev_q <= 1'b0;
      snap_state_q <= gw_pkg::LINK_OFFLINE;
      snap_fault_q <= gw_pkg::WORD_ZERO;
      snap_err_q <= gw_pkg::WORD_ZERO;
      snap_boff_q <= gw_pkg::WORD_ZERO;
      snap_ovr_q <= gw_pkg::WORD_ZERO;
      tick_q <= 32'h0000_0000;
      run_q <= 1'b0;
      ist_q <= 3'b000;
    end else if (mrst_q) begin
      // Restart of all state in this block, one cycle after the command
      sys_run_q <= 1'b0;
      local_run_q <= 1'b0;
      fclr_bit_q <= 1'b0;
      mrst_q <= 1'b0;
      sticky_q <= '0;
      err_cnt_q <= gw_pkg::WORD_ZERO;
      boff_cnt_q <= gw_pkg::WORD_ZERO;
      ovr_cnt_q <= gw_pkg::WORD_ZERO;
      bus_off_prev_q <= 1'b0;
      snap_state_q <= gw_pkg::LINK_OFFLINE;
      snap_fault_q <= gw_pkg::WORD_ZERO;
      snap_err_q <= gw_pkg::WORD_ZERO;
      snap_boff_q <= gw_pkg::WORD_ZERO;
      snap_ovr_q <= gw_pkg::WORD_ZERO;
      tick_q <= 32'h0000_0000;
      run_q <= 1'b0;
      ist_q <= 3'b000;
    end else begin
      sys_run_q <= sys_run_d;
      local_run_q <= local_run_d;
      fclr_bit_q <= fclr_bit_d;
      mrst_q <= mrst_d;
      sticky_q <= sticky_d;
      err_cnt_q <= err_cnt_d;
      boff_cnt_q <= boff_cnt_d;
      ovr_cnt_q <= ovr_cnt_d;
      bus_off_prev_q <= bus_off_prev_d;
      snap_state_q <= snap_state_d;
      snap_fault_q <= snap_fault_d;
      snap_err_q <= snap_err_d;
      snap_boff_q <= snap_boff_d;
      snap_ovr_q <= snap_ovr_d;
      tick_q <= tick_d;
      run_q <= run_d;
      ist_q <= ist_d;
    end
  end

  // Answer and data path registers; not touched by module reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resp_valid_q <= 1'b0;
      resp_rdata_q <= gw_pkg::WORD_ZERO;
      resp_err_q <= 1'b0;
      veh_out_q <= '0;
      host_in_q <= '0;
    end else begin
      resp_valid_q <= resp_valid_d;
      resp_rdata_q <= resp_rdata_d;
      resp_err_q <= resp_err_d;
      veh_out_q <= veh_out_sw;
      host_in_q <= host_in_sw;
    end
  end

  assign resp_valid = resp_valid_q;
  assign resp_rdata = resp_rdata_q;
  assign resp_err = resp_err_q;
  assign veh_out_data = veh_out_q;
  assign host_in_data = host_in_q;
  assign run_mode = run_q;
  assign module_reset = mrst_q;

  chk_run_gate: assert property (@(posedge clk) disable iff (!nrst)
    !mrst_q |=> run_q == ($past(sys_run_q) && $past(local_run_q)))
    else $error("run mode not gated by both run bits");
  chk_clear_faults: assert property (@(posedge clk) disable iff (!nrst)
    fault_clear && !mrst_q && !can_error_evt && !rx_overrun_evt |=>
    err_cnt_q == 16'h0000 && ovr_cnt_q == 16'h0000)
    else $error("fault clear left a counter");
  chk_reset_pulse: assert property (@(posedge clk) disable iff (!nrst)
    wr_cmd && req_wdata[4] && !mrst_q |=> mrst_q ##1
    (!mrst_q && !sys_run_q && sticky_q == '0))
    else $error("module reset did not restart state");
  chk_state_code: assert property (@(posedge clk) disable iff (!nrst)
    snap_state_q == 16'h8000 || snap_state_q == 16'h8001 ||
    snap_state_q == 16'h8002)
    else $error("bad link state code");
  chk_err_count: assert property (@(posedge clk) disable iff (!nrst)
    can_error_evt && !fault_clear && !mrst_q |=>
    err_cnt_q == $past(err_cnt_q) + 16'h0001)
    else $error("error counter missed an event");
  chk_busoff_count: assert property (@(posedge clk) disable iff (!nrst)
    bus_off && !bus_off_prev_q && !fault_clear && !mrst_q |=>
    boff_cnt_q == $past(boff_cnt_q) + 16'h0001)
    else $error("bus-off counter missed an event");
  chk_sticky_hold: assert property (@(posedge clk) disable iff (!nrst)
    sticky_q[2] && !fault_clear && !mrst_q |=> sticky_q[2])
    else $error("bus-off flag dropped without clear");
  chk_status_bits: assert property (@(posedge clk) disable iff (!nrst)
    !mrst_q ##1 !mrst_q |-> ist_q[0] == $past(run_q))
    else $error("input status run bit wrong");
  chk_swap_data: assert property (@(posedge clk) disable iff (!nrst)
    swap_en |=> veh_out_q[7:0] == $past(host_out_data[15:8]))
    else $error("byte swap not applied");
endmodule // gateway_status_command_bank
`default_nettype wire

/* File: sim/host_model.sv */
`default_nettype none
// Host side model: one word request at a time, answer awaited with a bound
module host_model (
  input wire logic clk,
  output logic req_valid,
  output logic req_write,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  input wire logic resp_valid,
  input wire logic [15:0] resp_rdata,
  input wire logic resp_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung; // Set when an answer never came
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
    hung = 1'b0;
  end
  // Strobe for one edge, then wait at most four edges for the answer
  task automatic xfer(input logic wr, input logic [15:0] a,
      input logic [15:0] wd, output logic [15:0] rd, output logic er);
    int n;
    rd = 16'hxxxx;
    er = 1'bx;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= wd;
    @(posedge clk);
    req_valid <= 1'b0;
    // Released lines show the inverse so a stale value never matches
    req_addr <= ~a;
    req_wdata <= ~wd;
    for (n = 0; n < 4; n++) begin
      @(posedge clk);
      if (resp_valid === 1'b1) begin
        rd = resp_rdata;
        er = resp_err;
        break;
      end
    end
    if (n == 4) begin
      hung = 1'b1;
    end
  endtask
endmodule // host_model
`default_nettype wire

/* File: sim/test_gateway_status_command_bank.sv */
`default_nettype none
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end
module test_gateway_status_command_bank;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RC = 16; // Short refresh period for simulation
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid, req_write, resp_valid, resp_err, run_mode, module_reset;
  logic [15:0] req_addr, req_wdata, resp_rdata, veh_out_data, host_in_data;
  logic link_online = 1'b0;
  logic link_init = 1'b0;
  logic claim_fail = 1'b0;
  logic warn = 1'b0;
  logic bus_off = 1'b0;
  logic can_err = 1'b0;
  logic overrun = 1'b0;
  logic frag_err = 1'b0;
  logic rxq_ovf = 1'b0;
  logic txq_ovf = 1'b0;
  logic swap_en = 1'b0;
  logic [15:0] host_out_data = 16'h0000;
  logic [15:0] veh_in_data = 16'h0000;
  int fail_count = 0;
  int n_compared = 0;
  int k;
  gateway_status_command_bank #(.REFRESH_CYCLES(RC), .DATA_WORDS(1))
      i_gateway_status_command_bank (.clk(clk), .nrst(nrst),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .resp_valid(resp_valid),
      .resp_rdata(resp_rdata), .resp_err(resp_err),
      .link_online(link_online), .link_initializing(link_init),
      .addr_claim_failed(claim_fail), .err_warning(warn),
      .bus_off(bus_off), .can_error_evt(can_err),
      .rx_overrun_evt(overrun), .fragment_transfer_error(frag_err),
      .rx_queue_overflow(rxq_ovf), .tx_queue_overflow(txq_ovf),
      .swap_en(swap_en), .host_out_data(host_out_data),
      .veh_in_data(veh_in_data), .veh_out_data(veh_out_data),
      .host_in_data(host_in_data), .run_mode(run_mode),
      .module_reset(module_reset));
  host_model i_host_model (.clk(clk), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .resp_valid(resp_valid), .resp_rdata(resp_rdata),
      .resp_err(resp_err));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // A lost answer ends the run at once
  always @(posedge clk) begin
    if (i_host_model.hung === 1'b1) begin
      fail_count++;
      print_verdict();
    end
  end
  // Write one word and compare the error flag of the answer
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
      input logic ee);
    logic [15:0] q;
    logic er;
    i_host_model.xfer(1'b1, a, d, q, er);
    `CHK("wr_err", ee, er)
  endtask
  // Read one word and compare data and error flag
  task automatic rd(input string nm, input logic [15:0] a,
      input logic [15:0] e, input logic ee);
    logic [15:0] q;
    logic er;
    i_host_model.xfer(1'b0, a, 16'h0000, q, er);
    `CHK(nm, e, q)
    `CHK("rd_err", ee, er)
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd("link", 16'h0101, 16'h8000, 1'b0);
    rd("faults", 16'h0102, 16'h0000, 1'b0);
    rd("spare", 16'h0106, 16'h0000, 1'b0);
    rd("status_hi", 16'h0002, 16'h0000, 1'b0);
    rd("run_hi", 16'h0402, 16'h0000, 1'b0);
    rd("unmapped", 16'h0200, 16'h0000, 1'b1);
    wr(16'h0101, 16'hFFFF, 1'b1);
    // Every pairing of system and local run bits
    for (k = 0; k < 4; k++) begin
      wr(16'h0401, {15'h0000, k[1]}, 1'b0);
      wr(16'h0403, {15'h0000, k[0]}, 1'b0);
      // Run mode registers at the answer edge; look one edge later
      @(posedge clk);
      `CHK("run_mode", k == 3, run_mode)
      rd("status", 16'h0001, {15'h0000, k == 3}, 1'b0);
    end
    // Link codes: offline, online, initializing
    for (k = 0; k < 3; k++) begin
      link_online <= k > 0;
      link_init <= k > 1;
      repeat (2 * RC + 4) @(posedge clk);
      rd("link", 16'h0101, 16'h8000 + 16'(k), 1'b0);
      rd("status", 16'h0001, {14'h0000, k > 0, 1'b1}, 1'b0);
    end
    link_online <= 1'b0;
    link_init <= 1'b0;
    // All fault sources at once, then a second error and bus-off edge
    claim_fail <= 1'b1;
    {warn, bus_off, can_err, overrun, frag_err, rxq_ovf, txq_ovf} <= 7'h7F;
    @(posedge clk);
    {warn, bus_off, overrun, frag_err, rxq_ovf, txq_ovf} <= 6'h00;
    @(posedge clk);
    bus_off <= 1'b1;
    can_err <= 1'b0;
    @(posedge clk);
    bus_off <= 1'b0;
    repeat (2 * RC + 4) @(posedge clk);
    rd("faults", 16'h0102, 16'h007F, 1'b0);
    rd("faults", 16'h0102, 16'h007F, 1'b0);
    rd("errors", 16'h0103, 16'h0002, 1'b0);
    rd("busoffs", 16'h0104, 16'h0002, 1'b0);
    rd("overruns", 16'h0105, 16'h0001, 1'b0);
    rd("status", 16'h0001, 16'h0005, 1'b0);
    // Clear while the claim failure persists: sticky bits and counts drop
    wr(16'h0403, 16'h0003, 1'b0);
    rd("faults", 16'h0102, 16'h0001, 1'b0);
    rd("errors", 16'h0103, 16'h0000, 1'b0);
    rd("busoffs", 16'h0104, 16'h0000, 1'b0);
    rd("overruns", 16'h0105, 16'h0000, 1'b0);
    claim_fail <= 1'b0;
    // Unused command bits neither stick nor act
    wr(16'h0403, 16'hFFEC, 1'b0);
    rd("cmd", 16'h0403, 16'h0000, 1'b0);
    wr(16'h0404, 16'hFFFF, 1'b0);
    rd("cmd_hi", 16'h0404, 16'h0000, 1'b0);
    // Module reset together with local run: run must not survive it
    wr(16'h0401, 16'h0001, 1'b0);
    wr(16'h0403, 16'h0011, 1'b0);
    for (k = 0; k < 4 && module_reset !== 1'b1; k++) begin
      @(posedge clk);
    end
    `CHK("mod_reset", 1'b1, module_reset)
    repeat (3) @(posedge clk);
    `CHK("run_mode", 1'b0, run_mode)
    rd("run_word", 16'h0401, 16'h0000, 1'b0);
    // Data path plain and swapped
    for (k = 0; k < 2; k++) begin
      swap_en <= k[0];
      host_out_data <= 16'h12A4;
      veh_in_data <= 16'h5BC6;
      repeat (2) @(posedge clk);
      `CHK("veh_out", k ? 16'hA412 : 16'h12A4, veh_out_data)
      `CHK("host_in", k ? 16'hC65B : 16'h5BC6, host_in_data)
    end
    print_verdict();
  end
endmodule // test_gateway_status_command_bank
`default_nettype wire
